// ==== core/uib_pkg.sv ====
// constants and carrier types for the interrupt ident / baud generator block
package uib_pkg;
  // register byte addresses on the bus
  localparam logic [4:0] ADDR_IDENT = 5'h00;
  localparam logic [4:0] ADDR_ENABLE = 5'h04;
  localparam logic [4:0] ADDR_DIV_LO = 5'h08;
  localparam logic [4:0] ADDR_DIV_HI = 5'h0c;
  localparam logic [4:0] ADDR_SCRATCH = 5'h10;
  localparam logic [4:0] ADDR_FIFO_CTRL = 5'h14;
  localparam logic [4:0] ADDR_MODEM_CTRL = 5'h18;
  localparam logic [4:0] ADDR_SPEED_CFG = 5'h1c;
  // reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_DIV_LO = 8'h00;
  localparam logic [7:0] RST_DIV_HI = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // field positions
  localparam int EN_RX_READY = 0;
  localparam int EN_TX_EMPTY = 1;
  localparam int EN_RX_STATUS = 2;
  localparam int EN_MODEM = 3;
  localparam int FC_FIFO_EN = 0;
  localparam int FC_TRIG_LO = 6;
  localparam int MC_IRQ_OUT_EN = 3;
  localparam int SC_HS_LO = 6;
  // interrupt codes, bits 3..0
  localparam logic [3:0] CODE_NONE = 4'h1;
  localparam logic [3:0] CODE_RX_STATUS = 4'h6;
  localparam logic [3:0] CODE_RX_READY = 4'h4;
  localparam logic [3:0] CODE_TIMEOUT = 4'hc;
  localparam logic [3:0] CODE_TX_EMPTY = 4'h2;
  localparam logic [3:0] CODE_MODEM = 4'h0;
  // receive fifo trigger levels
  localparam logic [4:0] TRIG_0 = 5'h01;
  localparam logic [4:0] TRIG_1 = 5'h04;
  localparam logic [4:0] TRIG_2 = 5'h08;
  localparam logic [4:0] TRIG_3 = 5'h0e;
  // timing: core clock, 24 MHz reference, prescale to 1.8461 MHz
  localparam int HCLK_KHZ = 250000;
  localparam int REF_KHZ = 24000;
  localparam logic [7:0] ACC_STEP = 8'(REF_KHZ / 1000);
  localparam logic [7:0] ACC_WRAP = 8'(HCLK_KHZ / 1000);
  localparam logic [3:0] PRESCALE = 4'hd;
  // timeout: four characters of ten bits at 16 ticks per bit
  localparam int CHAR_BITS = 10;
  localparam int TOUT_CHARS = 4;
  localparam logic [9:0] TOUT_TICKS = 10'(TOUT_CHARS * CHAR_BITS * 16);

  typedef struct packed {
    logic rx_err_evt;
    logic rx_data_valid;
    logic [4:0] rx_fifo_count;
    logic char_rcvd;
    logic rx_buf_rd;
    logic line_status_rd;
    logic tx_empty_evt;
    logic tx_buf_wr;
    logic [3:0] modem_chg_evt;
    logic modem_status_rd;
  } uib_uart_in_t;
endpackage

// ==== core/uib_baud.sv ====
// baud generator: 24 MHz reference, prescaler and 16-bit divisor
`timescale 1ns/1ps
`default_nettype none
module uib_baud (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [15:0] divisor,
  input wire logic high_speed,
  output logic tick16_r
);
  logic [7:0] acc_r;
  logic [8:0] acc_sum;
  logic ref_en_r;
  logic [3:0] pre_r;
  logic src_en;
  logic [15:0] cnt_r;

  // fractional accumulator keeps the 24 MHz average exact at 250 MHz
  assign acc_sum = {1'b0, acc_r} + {1'b0, uib_pkg::ACC_STEP};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 8'h00;
      ref_en_r <= 1'b0;
    end else if (acc_sum >= {1'b0, uib_pkg::ACC_WRAP}) begin
      acc_r <= 8'(acc_sum - {1'b0, uib_pkg::ACC_WRAP});
      ref_en_r <= 1'b1;
    end else begin
      acc_r <= acc_sum[7:0];
      ref_en_r <= 1'b0;
    end
  end

  // 24 MHz / 13 gives the 1.8461 MHz reference
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 4'h0;
    end else if (ref_en_r) begin
      if (pre_r == 4'(uib_pkg::PRESCALE - 4'h1)) begin
        pre_r <= 4'h0;
      end else begin
        pre_r <= 4'(pre_r + 4'h1);
      end
    end
  end

  // high speed bypasses the prescaler
  assign src_en = high_speed ? ref_en_r :
                  (ref_en_r && pre_r == 4'(uib_pkg::PRESCALE - 4'h1));

  // a zero divisor stops the generator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
      tick16_r <= 1'b0;
    end else if (divisor == 16'h0000) begin
      cnt_r <= 16'h0000;
      tick16_r <= 1'b0;
    end else if (src_en && cnt_r >= 16'(divisor - 16'h0001)) begin
      cnt_r <= 16'h0000;
      tick16_r <= 1'b1;
    end else begin
      if (src_en) begin
        cnt_r <= 16'(cnt_r + 16'h0001);
      end
      tick16_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== core/uib_core.sv ====
// interrupt identification, enables, baud generator and scratch over AHB-Lite
//
// Summary of operation
// - ident bits 7:6 follow fifo enable
// - ident bits 5:4 always zero
// - timeout sets bits 3:2 in fifo mode
// - ident bit 0 low when any enabled source pending
// - prioritised four-bit pending source code
// - status cleared by status read; ready by reads
// - tx empty cleared by write or ident read
// - modem change flags raise, status read clears
// - each source gated by its enable bit
// - enable bits: modem, status, tx, rx
// - enable register upper nibble reads zero
// - reference 24/13 MHz divided by 16-bit divisor
// - output is 16x bit clock for link
// - high speed divides 24 MHz directly
// - scratch register stores and returns host value
// - irq pin driven only with output enable
// - fifo mode when fifo control bit 0
// - trigger level 1, 4, 8 or 14
`timescale 1ns/1ps
`default_nettype none
module uib_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire uib_pkg::uib_uart_in_t uart_in,
  output logic irq_out,
  output logic irq_oe,
  output logic baud16_tick,
  output logic [7:0] fifo_ctrl,
  output logic [3:0] modem_changed
);
  logic [7:0] enable_r;
  logic [7:0] div_lo_r;
  logic [7:0] div_hi_r;
  logic [7:0] scratch_r;
  logic [7:0] fifo_ctrl_r;
  logic [7:0] modem_ctrl_r;
  logic [7:0] speed_cfg_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic wr_pend_r;
  logic [4:0] wr_addr_r;
  logic rx_status_r;
  logic tx_empty_r;
  logic [3:0] modem_chg_r;
  logic timeout_r;
  logic [9:0] idle_cnt_r;
  logic irq_out_r;
  logic irq_oe_r;
  logic tick16;
  logic addr_ok;
  logic rd_now;
  logic wr_now;
  logic fifo_mode;
  logic [4:0] trig;
  logic rx_ready;
  logic [3:0] code;
  logic [7:0] ident;
  logic ident_rd;
  logic [7:0] wdata;

  // trigger level lookup
  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'b00: trig_level = uib_pkg::TRIG_0;
      2'b01: trig_level = uib_pkg::TRIG_1;
      2'b10: trig_level = uib_pkg::TRIG_2;
      default: trig_level = uib_pkg::TRIG_3;
    endcase
  endfunction

  // only the eight word slots are decoded; anything else reads zero
  function automatic logic in_map(input logic [31:0] a);
    in_map = (a[31:5] == 27'h0000000) && (a[1:0] == 2'b00);
  endfunction

  assign fifo_mode = fifo_ctrl_r[uib_pkg::FC_FIFO_EN];
  assign trig = trig_level(fifo_ctrl_r[uib_pkg::FC_TRIG_LO +: 2]);
  assign wdata = hwdata[7:0];

  // bus address phase
  assign addr_ok = hsel && htrans[1] && hready && in_map(haddr);
  assign rd_now = addr_ok && !hwrite;
  assign wr_now = addr_ok && hwrite;
  assign ident_rd = rd_now && (haddr[4:0] == uib_pkg::ADDR_IDENT);

  // data ready is a level from the receive side: in fifo mode it
  // drops by itself once reads bring the count under the trigger
  always_comb begin
    if (fifo_mode) begin
      rx_ready = (uart_in.rx_fifo_count >= trig);
    end else begin
      rx_ready = uart_in.rx_data_valid;
    end
  end

  // priority encode of enabled sources
  always_comb begin
    if (rx_status_r && enable_r[uib_pkg::EN_RX_STATUS]) begin
      code = uib_pkg::CODE_RX_STATUS;
    end else if (rx_ready && enable_r[uib_pkg::EN_RX_READY]) begin
      code = uib_pkg::CODE_RX_READY;
    end else if (timeout_r && fifo_mode && enable_r[uib_pkg::EN_RX_READY]) begin
      code = uib_pkg::CODE_TIMEOUT;
    end else if (tx_empty_r && enable_r[uib_pkg::EN_TX_EMPTY]) begin
      code = uib_pkg::CODE_TX_EMPTY;
    end else if ((|modem_chg_r) && enable_r[uib_pkg::EN_MODEM]) begin
      code = uib_pkg::CODE_MODEM;
    end else begin
      code = uib_pkg::CODE_NONE;
    end
  end

  // timeout code only exists in fifo mode, so bit 3 is zero otherwise
  assign ident = {{2{fifo_mode}}, 2'b00, code};

  // bus response: zero wait state, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
    end
  end

  // read data captured in the address phase, so the ident
  // value seen by the host is the one that a read clear acts on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_now) begin
      case (haddr[4:0])
        uib_pkg::ADDR_IDENT: hrdata_r <= {24'h000000, ident};
        uib_pkg::ADDR_ENABLE: hrdata_r <= {28'h0000000, enable_r[3:0]};
        uib_pkg::ADDR_DIV_LO: hrdata_r <= {24'h000000, div_lo_r};
        uib_pkg::ADDR_DIV_HI: hrdata_r <= {24'h000000, div_hi_r};
        uib_pkg::ADDR_SCRATCH: hrdata_r <= {24'h000000, scratch_r};
        uib_pkg::ADDR_FIFO_CTRL: hrdata_r <= {24'h000000, fifo_ctrl_r};
        uib_pkg::ADDR_MODEM_CTRL: hrdata_r <= {24'h000000, modem_ctrl_r};
        uib_pkg::ADDR_SPEED_CFG: hrdata_r <= {24'h000000, speed_cfg_r};
        default: hrdata_r <= 32'h00000000;
      endcase
    end else begin
      hrdata_r <= 32'h00000000;
    end
  end

  // write address held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 5'h00;
    end else begin
      wr_pend_r <= wr_now;
      if (wr_now) begin
        wr_addr_r <= haddr[4:0];
      end
    end
  end

  // writable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_r <= uib_pkg::RST_ENABLE;
      div_lo_r <= uib_pkg::RST_DIV_LO;
      div_hi_r <= uib_pkg::RST_DIV_HI;
      scratch_r <= uib_pkg::RST_SCRATCH;
      fifo_ctrl_r <= uib_pkg::RST_CTRL;
      modem_ctrl_r <= uib_pkg::RST_CTRL;
      speed_cfg_r <= uib_pkg::RST_CTRL;
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        uib_pkg::ADDR_ENABLE: enable_r <= {4'h0, wdata[3:0]};
        uib_pkg::ADDR_DIV_LO: div_lo_r <= wdata;
        uib_pkg::ADDR_DIV_HI: div_hi_r <= wdata;
        uib_pkg::ADDR_SCRATCH: scratch_r <= wdata;
        uib_pkg::ADDR_FIFO_CTRL: fifo_ctrl_r <= wdata;
        uib_pkg::ADDR_MODEM_CTRL: modem_ctrl_r <= wdata;
        uib_pkg::ADDR_SPEED_CFG: speed_cfg_r <= wdata;
        default: enable_r <= enable_r;
      endcase
    end
  end

  // receive status: set wins over the line status read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_status_r <= 1'b0;
    end else if (uart_in.rx_err_evt) begin
      rx_status_r <= 1'b1;
    end else if (uart_in.line_status_rd) begin
      rx_status_r <= 1'b0;
    end
  end

  // transmit empty: cleared by a buffer write, or by an ident read
  // that reported this source; a new empty event still wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_empty_r <= 1'b0;
    end else if (uart_in.tx_empty_evt) begin
      tx_empty_r <= 1'b1;
    end else if (uart_in.tx_buf_wr) begin
      tx_empty_r <= 1'b0;
    end else if (ident_rd && code == uib_pkg::CODE_TX_EMPTY) begin
      tx_empty_r <= 1'b0;
    end
  end

  // modem change flags, per line; set wins over the status read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modem_chg_r <= 4'h0;
    end else if (uart_in.modem_status_rd) begin
      modem_chg_r <= uart_in.modem_chg_evt;
    end else begin
      modem_chg_r <= modem_chg_r | uart_in.modem_chg_evt;
    end
  end

  // idle timer in 16x ticks; restarts on a received character or a receive buffer read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_r <= 10'h000;
    end else if (uart_in.char_rcvd || uart_in.rx_buf_rd || !fifo_mode ||
                 uart_in.rx_fifo_count == 5'h00) begin
      idle_cnt_r <= 10'h000;
    end else if (tick16 && idle_cnt_r != uib_pkg::TOUT_TICKS) begin
      idle_cnt_r <= 10'(idle_cnt_r + 10'h001);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= (idle_cnt_r == uib_pkg::TOUT_TICKS);
    end
  end

  // interrupt pin: level plus output enable from modem control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_out_r <= 1'b0;
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= modem_ctrl_r[uib_pkg::MC_IRQ_OUT_EN];
      irq_out_r <= modem_ctrl_r[uib_pkg::MC_IRQ_OUT_EN] &&
                   (code != uib_pkg::CODE_NONE);
    end
  end

  uib_baud u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .divisor({div_hi_r, div_lo_r}),
    .high_speed(speed_cfg_r[uib_pkg::SC_HS_LO +: 2] == 2'b11),
    .tick16_r(tick16)
  );

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign irq_out = irq_out_r;
  assign irq_oe = irq_oe_r;
  assign baud16_tick = tick16;
  assign fifo_ctrl = fifo_ctrl_r;
  assign modem_changed = modem_chg_r;
endmodule
`default_nettype wire

// ==== tb/uib_host.sv ====
// host cpu model: single-word AHB-Lite master
`timescale 1ns/1ps
`default_nettype none
module uib_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ends one idle cycle late: a read right after a write sees the new value
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    // unused data lines toggle so a stale value cannot pass
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
    @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// ==== tb/uib_core_sva.sv ====
// port checker for the ident / baud block
`timescale 1ns/1ps
`default_nettype none
module uib_sva_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire uib_pkg::uib_uart_in_t uart_in,
  input wire logic irq_out,
  input wire logic irq_oe,
  input wire logic baud16_tick,
  input wire logic [7:0] fifo_ctrl,
  input wire logic [3:0] modem_changed
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_id;
  logic rd_en;
  assign rd_id = hsel && htrans[1] && hready && !hwrite && haddr == 32'h0;
  assign rd_en = hsel && htrans[1] && hready && !hwrite && haddr == 32'h4;
  a_ident_top: assert property (rd_id |=> hrdata[7:6] == {2{$past(fifo_ctrl[0])}})
    else $error("ident top bits wrong");
  a_ident_zero: assert property (rd_id |=> hrdata[5:4] == 2'h0)
    else $error("ident bits 5:4 set");
  a_bit3_plain: assert property (rd_id && !fifo_ctrl[0] |=> !hrdata[3])
    else $error("ident bit 3 set outside fifo mode");
  a_code_legal: assert property (rd_id |=>
    hrdata[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hc})
    else $error("ident code illegal");
  a_en_upper: assert property (rd_en |=> hrdata[7:4] == 4'h0)
    else $error("enable upper bits set");
  a_pin_gate: assert property (irq_out |-> irq_oe)
    else $error("irq driven while output disabled");
  a_tick_single: assert property (baud16_tick |=> !baud16_tick)
    else $error("tick longer than one cycle");
  a_modem_set: assert property (|uart_in.modem_chg_evt |=>
    (modem_changed & $past(uart_in.modem_chg_evt)) == $past(uart_in.modem_chg_evt))
    else $error("modem change flag not set");
endmodule
bind uib_core uib_sva_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .uart_in(uart_in),
  .irq_out(irq_out), .irq_oe(irq_oe), .baud16_tick(baud16_tick), .fifo_ctrl(fifo_ctrl),
  .modem_changed(modem_changed));
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the ident / enable / baud / scratch block
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [5:0] a; logic [7:0] w; logic [7:0] r;} uib_reg_row_t;
  typedef struct packed {logic [6:0] e; logic [7:0] id;} uib_evt_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  uib_pkg::uib_uart_in_t uart_in = '0;
  logic hsel, hwrite, hreadyout, irq_out, irq_oe, baud16_tick;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] fifo_ctrl;
  logic [3:0] modem_changed;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int ticks = 0;
  uib_reg_row_t regs [7] = '{'{6'h04, 8'hff, 8'h0f}, '{6'h00, 8'hff, 8'h01},
    '{6'h08, 8'h0c, 8'h0c}, '{6'h0c, 8'h5a, 8'h5a}, '{6'h10, 8'ha5, 8'ha5},
    '{6'h10, 8'h5a, 8'h5a}, '{6'h20, 8'hff, 8'h00}};
  // events: err, data valid, status read, tx empty, tx write, modem change, modem read
  uib_evt_row_t evs [9] = '{'{7'h02, 8'h00}, '{7'h08, 8'h02}, '{7'h00, 8'h00},
    '{7'h48, 8'h06}, '{7'h10, 8'h02}, '{7'h28, 8'h04}, '{7'h24, 8'h04},
    '{7'h00, 8'h00}, '{7'h01, 8'h01}};
  uib_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .uart_in(uart_in), .irq_out(irq_out), .irq_oe(irq_oe),
    .baud16_tick(baud16_tick), .fifo_ctrl(fifo_ctrl), .modem_changed(modem_changed));
  uib_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  always #2 hclk = ~hclk;
  // counted on the falling edge so it never races the stimulus
  always @(negedge hclk) if (baud16_tick === 1'b1) ticks++;
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      test_done;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.xfer(1'b1, {26'h0, a}, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [5:0] a);
    host.xfer(1'b0, {26'h0, a}, 32'h0, q);
  endtask
  task automatic ev(input logic [6:0] e);
    uib_pkg::uib_uart_in_t v;
    v = '0;
    v.rx_err_evt = e[6];
    v.rx_data_valid = e[5];
    v.line_status_rd = e[4];
    v.tx_empty_evt = e[3];
    v.tx_buf_wr = e[2];
    v.modem_chg_evt = {4{e[1]}};
    v.modem_status_rd = e[0];
    uart_in <= v;
    @(posedge hclk);
    v = '0;
    v.rx_data_valid = e[5];
    uart_in <= v;
    repeat (2) @(posedge hclk);
  endtask
  task automatic baud(input int n, input int lo, input int hi);
    int t0;
    t0 = ticks;
    repeat (n) @(posedge hclk);
    chk("baud_ticks", 32'(ticks - t0 >= lo && ticks - t0 <= hi), 32'h1);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      rd(6'(i * 4));
      chk("reset_value", q, (i == 0) ? 32'h1 : 32'h0);
    end
    $display("test reset done");
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].w);
      rd(regs[i].a);
      chk("reg_rw", q, {24'h0, regs[i].r});
    end
    $display("test registers done");
    wr(6'h04, 8'h0f);
    wr(6'h18, 8'h08);
    foreach (evs[i]) begin
      ev(evs[i].e);
      chk("irq_out", {31'h0, irq_out}, {31'h0, ~evs[i].id[0]});
      rd(6'h00);
      chk("ident", q, {24'h0, evs[i].id});
    end
    $display("test priorities done");
    chk("modem_cleared", {28'h0, modem_changed}, 32'h0);
    wr(6'h04, 8'h00);
    ev(7'h0a);
    rd(6'h00);
    chk("ident_masked", q, 32'h1);
    chk("modem_sticky", {28'h0, modem_changed}, 32'hf);
    chk("irq_masked", {31'h0, irq_out}, 32'h0);
    $display("test masking done");
    wr(6'h08, 8'h0c);
    wr(6'h0c, 8'h00);
    wr(6'h1c, 8'h00);
    baud(16250, 9, 11);
    wr(6'h08, 8'h01);
    wr(6'h1c, 8'hc0);
    baud(1042, 99, 101);
    $display("test baud done");
    wr(6'h04, 8'h01);
    wr(6'h14, 8'h01);
    chk("fifo_ctrl", {24'h0, fifo_ctrl}, 32'h01);
    uart_in <= '{rx_fifo_count: 5'h01, default: '0};
    repeat (3) @(posedge hclk);
    rd(6'h00);
    chk("fifo_ready", q, 32'hc4);
    wr(6'h14, 8'h41);
    rd(6'h00);
    chk("below_trigger", q, 32'hc1);
    repeat (7000) @(posedge hclk);
    rd(6'h00);
    chk("fifo_timeout", q, 32'hcc);
    $display("test fifo done");
    // second reset in mid-run: registers and fifo mode must fall back
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(6'h10);
    chk("scratch_reset", q, 32'h0);
    chk("fifo_ctrl_reset", {24'h0, fifo_ctrl}, 32'h0);
    rd(6'h00);
    chk("ident_reset", q, 32'h1);
    $display("test mid reset done");
    test_done;
  end
endmodule
`default_nettype wire
